//--- sbs_pkg.sv
/*
  Shared constants and types for the synchronous burst SRAM pair: the
  memory end, the controller end and the interface that joins them.
  Assumes one 100 MHz clock for both ends and no tool-specific setup.
*/
package sbs_pkg;

  // ---------------------------------------------------------------
  // widths and depths
  // ---------------------------------------------------------------
  localparam int ADDR_W    = 12;
  localparam int LANES     = 4;
  localparam int LANE_W    = 8;
  localparam int DATA_W    = LANES * LANE_W;
  localparam int MEM_DEPTH = 1 << ADDR_W;
  localparam int BURST_W   = 2;
  localparam int BUF_DEPTH = 2;
  localparam int LEVEL_W   = 2;

  // ---------------------------------------------------------------
  // latencies in clock edges from the command edge
  // ---------------------------------------------------------------
  localparam int PIPE_LAT  = 2;
  localparam int FLOW_LAT  = 1;

  // ---------------------------------------------------------------
  // values after reset, and the burst counter step
  // ---------------------------------------------------------------
  localparam logic [BURST_W-1:0] BURST_RST = 2'h0;
  localparam logic [ADDR_W-1:0]  ADDR_RST  = 12'h000;
  localparam logic [DATA_W-1:0]  DATA_RST  = 32'h0000_0000;
  localparam logic [LANES-1:0]   BE_N_RST  = 4'hF;
  localparam logic [BURST_W-1:0] BURST_ONE = 2'h1;

  typedef enum logic [1:0] {
    SBS_OP_NONE,
    SBS_OP_READ,
    SBS_OP_WRITE
  } sbs_op_e;

endpackage

//--- sbs_if.sv
/*
  Pin-level link between the controller end and the memory end.
  Assumes both ends run on the same clock; the shared data bus is
  resolved here from the two output enables, nothing drives it high-Z.
*/
`timescale 1ns/1ps
interface sbs_if;
  import sbs_pkg::*;

  logic [ADDR_W-1:0] addr;
  logic              advance_load;
  logic              write_n;
  logic [LANES-1:0]  byte_en_n;
  logic              chip_sel1_n;
  logic              chip_sel2;
  logic              chip_sel3_n;
  logic              clk_en_n;
  logic              out_en_n;
  logic              sleep_req;
  logic              flow_through_sel_n;
  logic              linear_order_n;
  logic [DATA_W-1:0] ctl_dq;
  logic              ctl_dq_oe;
  logic [DATA_W-1:0] mem_dq;
  logic              mem_dq_oe;
  logic [DATA_W-1:0] dq;

  // data_lane0..3 are dq[7:0] .. dq[31:24]; an undriven bus reads zero
  assign dq = mem_dq_oe ? mem_dq : (ctl_dq_oe ? ctl_dq : DATA_RST);

  modport ctl (
    output addr, advance_load, write_n, byte_en_n, chip_sel1_n,
    output chip_sel2, chip_sel3_n, clk_en_n, out_en_n, sleep_req,
    output flow_through_sel_n, linear_order_n, ctl_dq, ctl_dq_oe,
    input  dq
  );

  modport mem (
    input  addr, advance_load, write_n, byte_en_n, chip_sel1_n,
    input  chip_sel2, chip_sel3_n, clk_en_n, out_en_n, sleep_req,
    input  flow_through_sel_n, linear_order_n, dq,
    output mem_dq, mem_dq_oe
  );
endinterface

//--- sbs_buf.sv
/*
  Two-entry valid/ready buffer for read data returning to the user.
  Assumes the filler honours in_ready_o; level_o lets the filler stall
  its source a cycle ahead.
*/
`timescale 1ns/1ps
module sbs_buf
  import sbs_pkg::*;
#(
  parameter int W     = DATA_W,
  parameter int DEPTH = BUF_DEPTH
) (
  input  wire logic               clock_i,
  input  wire logic               rst_b_i,
  input  wire logic               in_valid_i,
  output logic                    in_ready_o,
  input  wire logic [W-1:0]       in_data_i,
  output logic                    out_valid_o,
  input  wire logic               out_ready_i,
  output logic [W-1:0]            out_data_o,
  output logic [LEVEL_W-1:0]      level_o
);
  logic [W-1:0]         slot_r [DEPTH];
  logic                 wr_ptr_r;
  logic                 rd_ptr_r;
  logic [LEVEL_W-1:0]   level_r;
  wire                  push = in_valid_i & in_ready_o;
  wire                  pop  = out_valid_o & out_ready_i;

  assign in_ready_o  = (level_r != LEVEL_W'(DEPTH));
  assign out_valid_o = (level_r != '0);
  assign out_data_o  = slot_r[rd_ptr_r];
  assign level_o     = level_r;

  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      wr_ptr_r <= 1'b0;
      rd_ptr_r <= 1'b0;
      level_r  <= '0;
    end else begin
      if (push) wr_ptr_r <= ~wr_ptr_r;
      if (pop)  rd_ptr_r <= ~rd_ptr_r;
      level_r <= level_r + LEVEL_W'(push) - LEVEL_W'(pop);
    end
  end

  // data slots need no reset; valid tracking guards them
  always_ff @(posedge clock_i) begin
    if (push) slot_r[wr_ptr_r] <= in_data_i;
  end
endmodule

//--- sbs_dev.sv
/*
  Memory end: synchronous burst SRAM with late write, pipelined or
  flow-through, a two-bit burst counter and per-lane byte writes.
  Read and write latencies match in each mode, so the bus turns
  from reads to writes with no idle cycle.
  Assumes a controller on sbs_if.mem sharing clock_i; mode pins are
  held static in operation; the array is never cleared, so a word
  reads unknown until written.
*/
// What this block does
// - clock gate high freezes all internal state except the status flops
// - sample inputs on rising edge, except three
// - controller holds advance low to load address
// - selected when sel1 low, sel2 high, sel3 low
// - read begins on enabled, selected, write high, load
// - pipelined read leaves output register next edge
// - write begins on enabled, selected, write low, load
// - each byte enable gates its own lane
// - write with no lanes enabled is no-op
// - pipelined write data due third edge
// - flow-through drives read data after address edge
// - flow-through write data due second edge
// - decode and counter identical in both modes
// - read and write latencies match per mode
// - low two address bits preset burst counter
// - flow-through pin low selects flow-through mode
// - order pin low selects linear burst
// - sleep high enters low-power state
// - advance high steps counter, uses generated address
// - burst counter wraps after four addresses
// - interleaved is start xor count; linear adds
// - output drivers off during write cycles
`timescale 1ns/1ps
module sbs_dev
  import sbs_pkg::*;
(
  input  wire logic              clock_i,
  input  wire logic              rst_b_i,
  sbs_if.mem                     bus,
  output logic                   asleep_o,
  output logic                   pipelined_o,
  output logic [BURST_W-1:0]     burst_pos_o
);
  // ---------------------------------------------------------------
  // storage and state
  // ---------------------------------------------------------------
  wire  [DATA_W-1:0]        core_q;
  sbs_op_e                  burst_op_r;
  logic [ADDR_W-1:0]        base_r;
  logic [BURST_W-1:0]       cnt_r;
  sbs_op_e                  s1_op_r;
  logic [ADDR_W-1:0]        s1_addr_r;
  logic [LANES-1:0]         s1_be_n_r;
  sbs_op_e                  s2_op_r;
  logic [ADDR_W-1:0]        s2_addr_r;
  logic [LANES-1:0]         s2_be_n_r;
  logic [DATA_W-1:0]        q_r;

  // ---------------------------------------------------------------
  // command decode
  // ---------------------------------------------------------------
  // a gated edge moves nothing, so a read on the bus stays driven
  // sleep is asynchronous, so it gates the edge like the clock gate
  wire run      = ~bus.clk_en_n & ~bus.sleep_req;
  wire selected = ~bus.chip_sel1_n & bus.chip_sel2
                  & ~bus.chip_sel3_n;
  wire load     = ~bus.advance_load;
  wire pipe     = bus.flow_through_sel_n;
  wire linear   = ~bus.linear_order_n;

  // a deselect load clears the burst op, so continues after it
  // stay deselected until the next selected load
  wire sbs_op_e new_op = !selected     ? SBS_OP_NONE
                       : bus.write_n   ? SBS_OP_READ
                       :                 SBS_OP_WRITE;

  // ---------------------------------------------------------------
  // burst address generation
  // ---------------------------------------------------------------
  // counter steps before use: first continue takes offset one,
  // the fourth wraps back to the loaded word
  wire [BURST_W-1:0] cnt_nxt   = cnt_r + BURST_ONE;
  wire [BURST_W-1:0] start     = base_r[BURST_W-1:0];
  wire [BURST_W-1:0] lin_low   = start + cnt_nxt;
  wire [BURST_W-1:0] ilv_low   = start ^ cnt_nxt;
  wire [BURST_W-1:0] burst_low = linear ? lin_low : ilv_low;
  wire [ADDR_W-1:0]  burst_addr =
    {base_r[ADDR_W-1:BURST_W], burst_low};

  wire sbs_op_e     acc_op   = load ? new_op : burst_op_r;
  wire [ADDR_W-1:0] acc_addr = load ? bus.addr : burst_addr;

  // ---------------------------------------------------------------
  // burst tracking, same in both modes
  // ---------------------------------------------------------------
  // preset bits load on every load, selected or not; a deselect
  // never reaches the array anyway
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      burst_op_r <= SBS_OP_NONE;
      base_r     <= ADDR_RST;
      cnt_r      <= BURST_RST;
    end else if (run) begin
      if (load) begin
        burst_op_r <= new_op;
        base_r     <= bus.addr;
        cnt_r      <= BURST_RST;
      end else begin
        cnt_r      <= cnt_nxt;
      end
    end
  end

  // ---------------------------------------------------------------
  // access pipeline: stage 1 after the command edge, stage 2 after
  // ---------------------------------------------------------------
  // byte enables ride with each cycle, so a continue may change
  // the lanes it writes
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      s1_op_r   <= SBS_OP_NONE;
      s1_addr_r <= ADDR_RST;
      s1_be_n_r <= BE_N_RST;
      s2_op_r   <= SBS_OP_NONE;
      s2_addr_r <= ADDR_RST;
      s2_be_n_r <= BE_N_RST;
    end else if (run) begin
      s1_op_r   <= acc_op;
      s1_addr_r <= acc_addr;
      s1_be_n_r <= bus.byte_en_n;
      s2_op_r   <= s1_op_r;
      s2_addr_r <= s1_addr_r;
      s2_be_n_r <= s1_be_n_r;
    end
  end

  // ---------------------------------------------------------------
  // late write: data sampled one edge (flow) or two (pipe) later
  // ---------------------------------------------------------------
  // write latency tracks read latency so reads turn to writes freely
  // no bypass: reading a word before its late data lands returns
  // the old contents; a stall delays both ends alike
  wire              wr_go   = run & (pipe ? (s2_op_r == SBS_OP_WRITE)
                                          : (s1_op_r == SBS_OP_WRITE));
  wire [ADDR_W-1:0] wr_addr = pipe ? s2_addr_r : s1_addr_r;
  wire [LANES-1:0]  wr_be_n = pipe ? s2_be_n_r : s1_be_n_r;

  genvar g;
  generate
    for (g = 0; g < LANES; g++) begin : g_lane
      // one array per lane keeps each lane's writes in one process
      logic [LANE_W-1:0] lane_r [MEM_DEPTH];
      wire               lane_we = wr_go & ~wr_be_n[g];

      // all lanes off leaves the word untouched: a write abort
      always_ff @(posedge clock_i) begin
        if (lane_we) begin
          lane_r[wr_addr] <= bus.dq[g*LANE_W +: LANE_W];
        end
      end

      // read as the access cycle runs; byte enables play no part
      assign core_q[g*LANE_W +: LANE_W] = lane_r[s1_addr_r];
    end
  endgenerate

  // ---------------------------------------------------------------
  // read path
  // ---------------------------------------------------------------
  // output register loads on every enabled edge, read or not;
  // only the drive enable decides what the pins show

  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      q_r <= DATA_RST;
    end else if (run) begin
      q_r <= core_q;
    end
  end

  wire rd_live = pipe ? (s2_op_r == SBS_OP_READ)
                      : (s1_op_r == SBS_OP_READ);
  // flow-through sends the array output straight to the pins
  // only read stages enable drivers, so writes never see them on
  assign bus.mem_dq    = pipe ? q_r : core_q;
  assign bus.mem_dq_oe = rd_live & ~bus.out_en_n
                         & ~bus.sleep_req;

  // ---------------------------------------------------------------
  // status
  // ---------------------------------------------------------------
  // status flops run on gated edges too, so asleep_o follows sleep_req one edge later;
  // burst_pos_o trails the counter by one edge
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      asleep_o    <= 1'b0;
      pipelined_o <= 1'b1;
      burst_pos_o <= BURST_RST;
    end else begin
      asleep_o    <= bus.sleep_req;
      pipelined_o <= pipe;
      burst_pos_o <= cnt_r;
    end
  end
endmodule

//--- sbs_ctl.sv
/*
  Controller end: turns user requests into SRAM pin cycles and returns
  read data through a two-entry buffer. Assumes sbs_dev on the far
  side of sbs_if on the same clock; mode inputs held static.
*/
`timescale 1ns/1ps
module sbs_ctl
  import sbs_pkg::*;
(
  input  wire logic              clock_i,
  input  wire logic              rst_b_i,
  sbs_if.ctl                     bus,
  input  wire logic              req_valid_i,
  output logic                   req_ready_o,
  input  wire logic              req_write_i,
  input  wire logic              req_burst_i,
  input  wire logic [ADDR_W-1:0] req_addr_i,
  input  wire logic [DATA_W-1:0] req_wdata_i,
  input  wire logic [LANES-1:0]  req_be_n_i,
  output logic                   rsp_valid_o,
  input  wire logic              rsp_ready_i,
  output logic [DATA_W-1:0]      rsp_data_o,
  input  wire logic              flow_mode_i,
  input  wire logic              linear_i,
  input  wire logic              sleep_i,
  input  wire logic              out_en_n_i
);
  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  sbs_op_e              pin_op_r;
  logic [DATA_W-1:0]    pin_data_r;
  sbs_op_e              t1_op_r;
  logic [DATA_W-1:0]    t1_data_r;
  sbs_op_e              t2_op_r;
  logic                 clk_en_n_r;
  logic                 buf_ready;
  logic [LEVEL_W-1:0]   buf_level;

  wire go     = ~clk_en_n_r;
  wire accept = req_valid_i & req_ready_o;
  wire flow   = ~bus.flow_through_sel_n;
  // read data lands one edge (flow) or two edges (pipe) after command
  wire land   = go & (flow ? (t1_op_r == SBS_OP_READ)
                           : (t2_op_r == SBS_OP_READ));
  wire push   = land & buf_ready;
  // stall a cycle early: anything buffered may block the next landing
  wire hold_nxt = (buf_level != '0) | push | sleep_i;

  wire sbs_op_e req_op = req_write_i ? SBS_OP_WRITE : SBS_OP_READ;
  wire sbs_op_e drv_op = flow ? pin_op_r : t1_op_r;
  wire [DATA_W-1:0] drv_data = flow ? pin_data_r : t1_data_r;

  assign req_ready_o = ~clk_en_n_r;
  assign bus.clk_en_n = clk_en_n_r;

  // ---------------------------------------------------------------
  // command pins
  // ---------------------------------------------------------------
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      bus.addr         <= ADDR_RST;
      bus.advance_load <= 1'b0;
      bus.write_n      <= 1'b1;
      bus.byte_en_n    <= BE_N_RST;
      bus.chip_sel1_n  <= 1'b1;
      bus.chip_sel2    <= 1'b0;
      bus.chip_sel3_n  <= 1'b1;
      pin_op_r         <= SBS_OP_NONE;
      pin_data_r       <= DATA_RST;
    end else if (go) begin
      bus.addr         <= req_addr_i;
      bus.advance_load <= accept & req_burst_i;
      bus.write_n      <= ~(accept & req_write_i);
      bus.byte_en_n    <= accept ? req_be_n_i : BE_N_RST;
      bus.chip_sel1_n  <= ~accept;
      bus.chip_sel2    <= accept;
      bus.chip_sel3_n  <= ~accept;
      pin_op_r         <= accept ? req_op : SBS_OP_NONE;
      pin_data_r       <= req_wdata_i;
    end
  end

  // ---------------------------------------------------------------
  // in-flight tracking and write data drive
  // ---------------------------------------------------------------
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      t1_op_r       <= SBS_OP_NONE;
      t1_data_r     <= DATA_RST;
      t2_op_r       <= SBS_OP_NONE;
      bus.ctl_dq    <= DATA_RST;
      bus.ctl_dq_oe <= 1'b0;
    end else if (go) begin
      t1_op_r       <= pin_op_r;
      t1_data_r     <= pin_data_r;
      t2_op_r       <= t1_op_r;
      bus.ctl_dq    <= drv_data;
      bus.ctl_dq_oe <= (drv_op == SBS_OP_WRITE);
    end
  end

  // ---------------------------------------------------------------
  // clock gate and mode pins
  // ---------------------------------------------------------------
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      clk_en_n_r             <= 1'b1;
      bus.sleep_req          <= 1'b0;
      bus.out_en_n           <= 1'b1;
      bus.flow_through_sel_n <= 1'b1;
      bus.linear_order_n     <= 1'b1;
    end else begin
      clk_en_n_r             <= hold_nxt;
      bus.sleep_req          <= sleep_i;
      bus.out_en_n           <= out_en_n_i;
      bus.flow_through_sel_n <= ~flow_mode_i;
      bus.linear_order_n     <= ~linear_i;
    end
  end

  // ---------------------------------------------------------------
  // read return buffer
  // ---------------------------------------------------------------
  sbs_buf #(
    .W     (DATA_W),
    .DEPTH (BUF_DEPTH)
  ) u_buf (
    .clock_i     (clock_i),
    .rst_b_i     (rst_b_i),
    .in_valid_i  (land),
    .in_ready_o  (buf_ready),
    .in_data_i   (bus.dq),
    .out_valid_o (rsp_valid_o),
    .out_ready_i (rsp_ready_i),
    .out_data_o  (rsp_data_o),
    .level_o     (buf_level)
  );
endmodule

//--- sbs_link_properties.sv
/*
  Concurrent checks on the pin link between controller and memory end.
  Assumes one clock for both ends and an active-low asynchronous reset;
  the testbench instantiates this beside the link interface.
*/
`timescale 1ns/1ps
module sbs_link_props
  import sbs_pkg::*;
(
  input  wire logic              clock_i,
  input  wire logic              rst_b_i,
  input  wire logic              advance_load,
  input  wire logic              write_n,
  input  wire logic [LANES-1:0]  byte_en_n,
  input  wire logic              chip_sel1_n,
  input  wire logic              chip_sel2,
  input  wire logic              chip_sel3_n,
  input  wire logic              clk_en_n,
  input  wire logic              out_en_n,
  input  wire logic              sleep_req,
  input  wire logic              flow_through_sel_n,
  input  wire logic              ctl_dq_oe,
  input  wire logic [DATA_W-1:0] mem_dq,
  input  wire logic              mem_dq_oe
);
  // ---------------------------------------------------------------
  // command decode seen on the pins
  // ---------------------------------------------------------------
  wire logic en      = !clk_en_n && !sleep_req;
  wire logic sel     = !chip_sel1_n && chip_sel2 && !chip_sel3_n;
  wire logic load    = en && !advance_load;
  wire logic rd_take = load && sel && write_n;
  wire logic wr_take = load && sel && !write_n && (byte_en_n != 4'hF);
  wire logic dsel    = load && !sel;
  wire logic pipe    = flow_through_sel_n;
  wire logic no_gate = !out_en_n && !sleep_req;

  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rst_b_i);

  // ---------------------------------------------------------------
  // output drive
  // ---------------------------------------------------------------
  a_outen_forces_off: assert property (out_en_n |-> !mem_dq_oe)
    else $error("memory drives bus with output enable off");
  a_sleep_forces_off: assert property (sleep_req |-> !mem_dq_oe)
    else $error("memory drives bus while asleep");
  a_bus_no_clash: assert property (!(mem_dq_oe && ctl_dq_oe))
    else $error("both ends drive the data bus");

  // ---------------------------------------------------------------
  // latencies; a stalled edge in between would shift them
  // ---------------------------------------------------------------
  a_pipe_read_drive: assert property (rd_take && pipe ##1 en
    |=> mem_dq_oe || !no_gate)
    else $error("pipelined read data not driven two edges on");
  a_flow_read_drive: assert property (rd_take && !pipe
    |=> mem_dq_oe || !no_gate)
    else $error("flow-through read data not driven one edge on");
  a_pipe_wdata_due: assert property (wr_take && pipe ##1 !clk_en_n
    |=> ctl_dq_oe)
    else $error("pipelined write data not presented on time");
  a_flow_wdata_due: assert property (wr_take && !pipe |=> ctl_dq_oe)
    else $error("flow-through write data not presented on time");
  a_desel_pipe_quiet: assert property (dsel && pipe ##1 en
    |=> !mem_dq_oe)
    else $error("deselected pipelined cycle drives the bus");
  a_desel_flow_quiet: assert property (dsel && !pipe |=> !mem_dq_oe)
    else $error("deselected flow-through cycle drives the bus");
  a_stall_holds_bus: assert property (clk_en_n && no_gate ##1 no_gate
    |-> $stable(mem_dq_oe) && (!mem_dq_oe || $stable(mem_dq)))
    else $error("read output moved on an ignored edge");
endmodule

//--- test_sync_burst_sram_late_write.sv
/*
  Self-checking bench: controller and memory end joined by the link
  interface, exercised from the controller's user side in all four
  mode combinations. Assumes the design files and package compiled.
*/
`timescale 1ns/1ps
module test_sync_burst_sram_late_write
  import sbs_pkg::*;
;
  typedef struct {
    logic              wr;
    logic [ADDR_W-1:0] a;
    logic [DATA_W-1:0] d;
    logic [LANES-1:0]  be;
  } sbs_row_s;

  logic              clock_i     = 1'b0;
  logic              rst_b_i     = 1'b0;
  logic              req_valid_i = 1'b0;
  logic              req_write_i = 1'b0;
  logic              req_burst_i = 1'b0;
  logic [ADDR_W-1:0] req_addr_i  = ADDR_RST;
  logic [DATA_W-1:0] req_wdata_i = DATA_RST;
  logic [LANES-1:0]  req_be_n_i  = BE_N_RST;
  logic              rsp_ready_i = 1'b1;
  logic              flow_mode_i = 1'b0;
  logic              linear_i    = 1'b0;
  logic              sleep_i     = 1'b0;
  logic              out_en_n_i  = 1'b0;
  logic              req_ready_o;
  logic              rsp_valid_o;
  logic [DATA_W-1:0] rsp_data_o;
  logic              asleep_o;
  logic              pipelined_o;
  logic [BURST_W-1:0] burst_pos_o;
  logic [DATA_W-1:0] exp_q[$];
  logic [1:0]        s;
  int                miscompares = 0;
  int                n_checks    = 0;
  int                cycles      = 0;

  // reads compare against the value left by the writes before them
  sbs_row_s rows [10] = '{
    '{1'b1, 12'h010, 32'hA1B2C3D4, 4'h0}, '{1'b0, 12'h010, 32'hA1B2C3D4, 4'hF},
    '{1'b1, 12'h010, 32'h55667788, 4'hA}, '{1'b0, 12'h010, 32'hA166C388, 4'hF},
    '{1'b1, 12'h010, 32'hFFFFFFFF, 4'hF}, '{1'b0, 12'h010, 32'hA166C388, 4'hF},
    '{1'b1, 12'h011, 32'h11111111, 4'h0}, '{1'b1, 12'h012, 32'h22222222, 4'h0},
    '{1'b0, 12'h011, 32'h11111111, 4'hF}, '{1'b0, 12'h012, 32'h22222222, 4'hF}};

  sbs_if i_sbs_if();

  sbs_ctl i_sbs_ctl (
    .clock_i(clock_i), .rst_b_i(rst_b_i), .bus(i_sbs_if),
    .req_valid_i(req_valid_i), .req_ready_o(req_ready_o),
    .req_write_i(req_write_i), .req_burst_i(req_burst_i),
    .req_addr_i(req_addr_i), .req_wdata_i(req_wdata_i),
    .req_be_n_i(req_be_n_i), .rsp_valid_o(rsp_valid_o),
    .rsp_ready_i(rsp_ready_i), .rsp_data_o(rsp_data_o),
    .flow_mode_i(flow_mode_i), .linear_i(linear_i),
    .sleep_i(sleep_i), .out_en_n_i(out_en_n_i));

  sbs_dev i_sbs_dev (
    .clock_i(clock_i), .rst_b_i(rst_b_i), .bus(i_sbs_if),
    .asleep_o(asleep_o), .pipelined_o(pipelined_o),
    .burst_pos_o(burst_pos_o));

  sbs_link_props i_sbs_link_props (
    .clock_i(clock_i), .rst_b_i(rst_b_i),
    .advance_load(i_sbs_if.advance_load), .write_n(i_sbs_if.write_n),
    .byte_en_n(i_sbs_if.byte_en_n), .chip_sel1_n(i_sbs_if.chip_sel1_n),
    .chip_sel2(i_sbs_if.chip_sel2), .chip_sel3_n(i_sbs_if.chip_sel3_n),
    .clk_en_n(i_sbs_if.clk_en_n), .out_en_n(i_sbs_if.out_en_n),
    .sleep_req(i_sbs_if.sleep_req), .ctl_dq_oe(i_sbs_if.ctl_dq_oe),
    .flow_through_sel_n(i_sbs_if.flow_through_sel_n),
    .mem_dq(i_sbs_if.mem_dq), .mem_dq_oe(i_sbs_if.mem_dq_oe));

  // ---------------------------------------------------------------
  // clock, timeout and shared tasks
  // ---------------------------------------------------------------
  always #5 clock_i = ~clock_i;

  task automatic report_and_stop();
    if (miscompares == 0 && n_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  // the whole run needs well under 2000 cycles
  always @(posedge clock_i) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      miscompares++;
      report_and_stop();
    end
  end

  task automatic chk(input logic [DATA_W-1:0] seen, exp);
    n_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // valid stays up after the take so that requests can run back to back
  task automatic send(input logic wr, bu, input logic [ADDR_W-1:0] a,
                      input logic [DATA_W-1:0] d, input logic [LANES-1:0] be);
    {req_valid_i, req_write_i, req_burst_i} = {1'b1, wr, bu};
    {req_addr_i, req_wdata_i, req_be_n_i} = {a, d, be};
    while (req_ready_o !== 1'b1) begin
      @(posedge clock_i);
      #1;
    end
    @(posedge clock_i);
    #1;
  endtask

  // idle edges keep a read clear of a write still landing in the array
  task automatic release_req();
    req_valid_i = 1'b0;
    repeat (3) @(posedge clock_i);
    #1;
  endtask

  task automatic wait_drain();
    while (exp_q.size() != 0) begin
      @(posedge clock_i);
      #1;
    end
  endtask

  task automatic do_reset(input logic flow, lin);
    rst_b_i = 1'b0;
    {flow_mode_i, linear_i} = {flow, lin};
    repeat (3) @(posedge clock_i);
    #1;
    chk(32'({req_ready_o, rsp_valid_o}), 32'h0);
    rst_b_i = 1'b1;
    repeat (3) @(posedge clock_i);
    #1;
    chk(32'(pipelined_o), 32'(!flow));
  endtask

  function automatic logic [1:0] seq(input logic [1:0] st, n, input logic lin);
    return lin ? st + n : st ^ n;
  endfunction

  // the transfer happens at the next rising edge when both are high
  always @(negedge clock_i) begin
    if (rst_b_i && rsp_valid_o === 1'b1 && rsp_ready_i === 1'b1) begin
      if (exp_q.size() == 0) chk(32'h0, 32'h1);
      else chk(rsp_data_o, exp_q.pop_front());
    end
  end

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    for (int m = 0; m < 4; m++) begin
      do_reset(m[0], m[1]);
      for (int r = 0; r < 10; r++) begin
        if (!rows[r].wr) exp_q.push_back(rows[r].d);
        send(rows[r].wr, 1'b0, rows[r].a, rows[r].d, rows[r].be);
        release_req();
      end
      wait_drain();
      s = 2'(m + 1);
      for (int n = 0; n < 8; n++) begin
        if (n > 3) exp_q.push_back(32'hC0DE0000 + 32'(n - 4));
        send(n < 4, n % 4 != 0, {10'h080, s}, 32'hC0DE0000 + 32'(n), 4'h0);
        if (n == 5) chk(32'(burst_pos_o), 32'h3);
      end
      release_req();
      wait_drain();
      for (int n = 1; n < 4; n += 2) begin
        exp_q.push_back(32'hC0DE0000 + 32'(n));
        send(1'b0, 1'b0, {10'h080, seq(s, 2'(n), m[1])}, '0, 4'hF);
        release_req();
      end
      wait_drain();
    end
    rsp_ready_i = 1'b0;
    exp_q.push_back(32'h11111111);
    send(1'b0, 1'b0, 12'h011, '0, 4'hF);
    release_req();
    repeat (8) @(posedge clock_i);
    #1;
    chk(32'({rsp_valid_o, req_ready_o}), 32'h2);
    rsp_ready_i = 1'b1;
    wait_drain();
    out_en_n_i = 1'b1;
    exp_q.push_back(DATA_RST);
    send(1'b0, 1'b0, 12'h011, '0, 4'hF);
    release_req();
    wait_drain();
    out_en_n_i = 1'b0;
    sleep_i = 1'b1;
    repeat (5) @(posedge clock_i);
    #1;
    chk(32'({asleep_o, req_ready_o, i_sbs_if.mem_dq_oe}), 32'h4);
    sleep_i = 1'b0;
    repeat (5) @(posedge clock_i);
    #1;
    exp_q.push_back(32'h22222222);
    send(1'b0, 1'b0, 12'h012, '0, 4'hF);
    release_req();
    wait_drain();
    send(1'b0, 1'b0, 12'h010, '0, 4'hF);
    req_valid_i = 1'b0;
    rst_b_i = 1'b0;
    #1;
    chk(32'({rsp_valid_o, req_ready_o}), 32'h0);
    repeat (3) @(posedge clock_i);
    #1;
    rst_b_i = 1'b1;
    repeat (6) @(posedge clock_i);
    #1;
    chk(32'({rsp_valid_o, req_ready_o}), 32'h1);
    chk(32'(exp_q.size()), 32'h0);
    report_and_stop();
  end
endmodule
